// >>> rtl/cfs_pkg.sv
package cfs_pkg;

    typedef enum logic [1:0] {
        CFS_MODE_MULTI,
        CFS_MODE_I2S,
        CFS_MODE_ACLINK,
        CFS_MODE_RSVD
    } cfs_mode_t;

    localparam int unsigned DIV_W         = 12;
    localparam int unsigned FLEN_W        = 4;
    localparam int unsigned WSIZE_W       = 4;
    localparam int unsigned SLOT_CNT_W    = 4;
    localparam int unsigned BIT_CNT_W     = 4;
    localparam logic [11:0] DIV_RESET     = 12'h000;
    localparam logic [11:0] DIV_OFF       = 12'h000;
    localparam logic [3:0]  BIT_CNT_RESET = 4'h0;
    localparam logic [3:0]  SLOT_CNT_RESET = 4'h0;
    localparam logic [3:0]  CNT_ONE       = 4'h1;

    typedef struct packed {
        cfs_mode_t        mode;
        logic [11:0]      divisor;
        logic             clk_dir_in;
        logic [3:0]       frame_len;
        logic [3:0]       word_size;
    } cfs_cfg_t;

    typedef struct packed {
        logic             frame_start;
        logic             slot_start;
        logic             bit_strobe;
        logic             frame_done;
        logic [3:0]       slot_index;
        logic [3:0]       bit_index;
    } cfs_status_t;

endpackage

// >>> rtl/cfs_bit_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_bit_clock_gen (
    input  wire logic        sys_clk,    // Instruction clock
    input  wire logic        rst_n,      // Sync reset, active low
    input  wire logic [11:0] divisor,    // Half-period count minus one
    input  wire logic        dir_in,     // Bit clock pin is an input
    output logic             gen_on,     // Generator running
    output logic             clk_level,  // Generated bit clock level
    output logic             rise_pulse  // One cycle at generated rising edge
);
    logic [11:0] cnt_r, cnt_nxt;
    logic        lvl_r, lvl_nxt;
    logic        rise_r, rise_nxt;
    logic        on;

    assign on = (divisor != cfs_pkg::DIV_OFF) && !dir_in; // R09 R12

    always_comb begin
        cnt_nxt  = cnt_r;
        lvl_nxt  = lvl_r;
        rise_nxt = 1'b0;
        if (!on) begin
            cnt_nxt = cfs_pkg::DIV_RESET;
            lvl_nxt = 1'b0;
        end else if (cnt_r >= divisor) begin // R08 R10
            cnt_nxt  = cfs_pkg::DIV_RESET;
            lvl_nxt  = !lvl_r;
            rise_nxt = !lvl_r;
        end else begin
            cnt_nxt = cnt_r + 12'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r  <= cfs_pkg::DIV_RESET;
            lvl_r  <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            lvl_r  <= lvl_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign gen_on     = on;
    assign clk_level  = lvl_r;
    assign rise_pulse = rise_r;

    a_half_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (on && $stable(divisor) && cnt_r == divisor) |=> (lvl_r != $past(lvl_r))) // R10
        else $error("bit clock failed to toggle at divisor count");
    a_gen_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (divisor == cfs_pkg::DIV_OFF) |=> !lvl_r) // R09
        else $error("bit clock runs with divisor zero");
endmodule // cfs_bit_clock_gen
`default_nettype wire

// >>> rtl/cfs_edge_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_edge_sampler (
    input  wire logic sys_clk,   // Instruction clock
    input  wire logic rst_n,     // Sync reset, active low
    input  wire logic bit_tick,  // Sampling bit clock edge
    input  wire logic sync_in,   // Frame sync pin level
    output logic      level,     // Frame sync at this tick
    output logic      rose,      // Rise since last sample
    output logic      fell       // Fall since last sample
);
    logic cur_r, cur_nxt;

    // Pin judged at the tick itself, so the start lands one bit later
    always_comb begin
        cur_nxt = cur_r;
        if (bit_tick) begin
            cur_nxt = sync_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur_r <= 1'b0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign level = sync_in;
    assign rose  = sync_in && !cur_r;
    assign fell  = !sync_in && cur_r;
endmodule // cfs_edge_sampler
`default_nettype wire

// >>> rtl/cfs_frame_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R01 - Multi-channel: frame starts one bit after sync
// R02 - Multi-channel sync pulse resets frame generator
// R03 - I2S: word starts one bit after edge
// R04 - I2S: either edge resets frame generator
// R05 - AC-Link: tag slot one bit after sync
// R06 - Software matches frame length in slave mode
// R07 - Ignore sync pulses until frame completes
// R08 - Bit clock from 12-bit time base
// R09 - Zero divisor disables bit clock generator
// R10 - Bit clock equals clock over 2(div+1)
// R11 - External clock: software sets divisor zero
// R12 - External clock input ignores divisor
// R13 - Drive pin from generator, else input
module cfs_frame_sync (
    input  wire logic                 sys_clk,       // 20 MHz instruction clock
    input  wire logic                 rst_n,         // Sync reset, active low
    input  wire cfs_pkg::cfs_mode_t   mode,          // Framing mode
    input  wire logic [11:0]          bit_clock_divisor,    // Bit clock divisor
    input  wire logic                 bit_clock_direction,  // 1 = bit clock pin input
    input  wire logic [3:0]           frame_length_setting, // Words per frame minus one, unused in I2S
    input  wire logic [3:0]           word_size_setting,    // Bits per word minus one
    input  wire logic                 frame_sync_pin,       // Frame sync pin level
    input  wire logic                 serial_bit_clock_pin_i, // Bit clock pin input
    output logic                      serial_bit_clock_pin_o, // Bit clock pin output
    output logic                      serial_bit_clock_pin_oe, // Bit clock pin enable
    output cfs_pkg::cfs_status_t      status,        // Frame timing strobes
    output logic                      busy           // Frame transfer in progress
);
    logic        gen_on, gen_lvl, gen_rise;
    logic        ext_cur_r, ext_cur_nxt;
    logic        ext_prv_r, ext_prv_nxt;
    logic        tick;
    logic        fs_lvl, fs_rose, fs_fell;
    logic        trig;

    cfs_bit_clock_gen u_gen (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .divisor    (bit_clock_divisor),
        .dir_in     (bit_clock_direction),
        .gen_on     (gen_on),
        .clk_level  (gen_lvl),
        .rise_pulse (gen_rise)
    );

    // External bit clock edge detect, inputs synchronous to sys_clk
    always_comb begin
        ext_cur_nxt = serial_bit_clock_pin_i;
        ext_prv_nxt = ext_cur_r;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ext_cur_r <= 1'b0;
            ext_prv_r <= 1'b0;
        end else begin
            ext_cur_r <= ext_cur_nxt;
            ext_prv_r <= ext_prv_nxt;
        end
    end

    assign tick = bit_clock_direction ? (ext_cur_r && !ext_prv_r) : gen_rise; // R12

    cfs_edge_sampler u_fs (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .bit_tick (tick),
        .sync_in  (frame_sync_pin),
        .level    (fs_lvl),
        .rose     (fs_rose),
        .fell     (fs_fell)
    );

    // Sync qualified per mode
    always_comb begin
        case (mode)
            cfs_pkg::CFS_MODE_MULTI:  trig = fs_lvl;            // R01 R02
            cfs_pkg::CFS_MODE_I2S:    trig = fs_rose || fs_fell; // R03 R04
            cfs_pkg::CFS_MODE_ACLINK: trig = fs_lvl;            // R05
            default:                  trig = 1'b0;
        endcase
    end

    typedef enum logic [1:0] {
        CFS_IDLE,
        CFS_ARMED,
        CFS_XFER
    } cfs_state_t;

    cfs_state_t  st_r, st_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic [3:0]  slot_r, slot_nxt;
    logic        last_bit, last_slot, words_done;
    cfs_pkg::cfs_status_t stat_r, stat_nxt;
    logic        clk_o_r, clk_o_nxt;
    logic        clk_oe_r, clk_oe_nxt;
    logic        busy_r, busy_nxt;

    assign last_bit   = (bit_r == word_size_setting);
    assign last_slot  = (slot_r == frame_length_setting);
    // I2S frame is one word; other modes use the frame length setting
    assign words_done = (mode == cfs_pkg::CFS_MODE_I2S) ? 1'b1 : last_slot;

    always_comb begin
        st_nxt   = st_r;
        bit_nxt  = bit_r;
        slot_nxt = slot_r;
        stat_nxt = '0;
        stat_nxt.slot_index = slot_r;
        stat_nxt.bit_index  = bit_r;
        if (tick) begin
            case (st_r)
                CFS_IDLE: begin
                    if (trig) begin
                        st_nxt = CFS_ARMED;
                    end
                end
                CFS_ARMED: begin
                    // One bit clock after the sampled sync
                    st_nxt   = CFS_XFER; // R01 R03 R05
                    bit_nxt  = cfs_pkg::BIT_CNT_RESET; // R02 R04
                    slot_nxt = cfs_pkg::SLOT_CNT_RESET;
                    stat_nxt.frame_start = 1'b1;
                    stat_nxt.slot_start  = 1'b1;
                    stat_nxt.bit_strobe  = 1'b1;
                    stat_nxt.slot_index  = cfs_pkg::SLOT_CNT_RESET;
                    stat_nxt.bit_index   = cfs_pkg::BIT_CNT_RESET;
                end
                CFS_XFER: begin
                    // Sync ignored until frame ends
                    if (last_bit && words_done) begin // R07
                        stat_nxt.frame_done = 1'b1;
                        st_nxt = trig ? CFS_ARMED : CFS_IDLE;
                    end else begin
                        stat_nxt.bit_strobe = 1'b1;
                        if (last_bit) begin
                            bit_nxt  = cfs_pkg::BIT_CNT_RESET;
                            slot_nxt = slot_r + cfs_pkg::CNT_ONE;
                            stat_nxt.slot_start = 1'b1;
                            stat_nxt.slot_index = slot_r + cfs_pkg::CNT_ONE;
                            stat_nxt.bit_index  = cfs_pkg::BIT_CNT_RESET;
                        end else begin
                            bit_nxt = bit_r + cfs_pkg::CNT_ONE;
                            stat_nxt.bit_index = bit_r + cfs_pkg::CNT_ONE;
                        end
                    end
                end
                default: st_nxt = CFS_IDLE;
            endcase
        end
        clk_o_nxt  = gen_lvl;
        clk_oe_nxt = gen_on; // R13
        busy_nxt   = (st_nxt != CFS_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r     <= CFS_IDLE;
            bit_r    <= cfs_pkg::BIT_CNT_RESET;
            slot_r   <= cfs_pkg::SLOT_CNT_RESET;
            stat_r   <= '0;
            clk_o_r  <= 1'b0;
            clk_oe_r <= 1'b0;
            busy_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            bit_r    <= bit_nxt;
            slot_r   <= slot_nxt;
            stat_r   <= stat_nxt;
            clk_o_r  <= clk_o_nxt;
            clk_oe_r <= clk_oe_nxt;
            busy_r   <= busy_nxt;
        end
    end

    assign serial_bit_clock_pin_o  = clk_o_r;
    assign serial_bit_clock_pin_oe = clk_oe_r;
    assign status = stat_r;
    assign busy   = busy_r;

    a_start_after_sync: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && st_r == CFS_ARMED) |=> status.frame_start) // R01
        else $error("frame did not start one bit after sync");
    a_no_start_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_r == CFS_IDLE) |=> !status.frame_start) // R07
        else $error("frame started without armed sync");
    a_ignore_in_xfer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && st_r == CFS_XFER && !(last_bit && words_done)) |=> (st_r == CFS_XFER)) // R07
        else $error("transfer disturbed before frame end");
    a_i2s_edge_arm: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && st_r == CFS_IDLE && mode == cfs_pkg::CFS_MODE_I2S && (fs_rose || fs_fell))
        |=> (st_r == CFS_ARMED)) // R03
        else $error("i2s edge did not arm the frame");
    a_multi_level_arm: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && st_r == CFS_IDLE && mode != cfs_pkg::CFS_MODE_I2S
         && mode != cfs_pkg::CFS_MODE_RSVD && fs_lvl) |=> (st_r == CFS_ARMED)) // R05
        else $error("high sync did not arm the frame");
    a_reset_counters: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status.frame_start |-> (bit_r == 4'h0 && slot_r == 4'h0)) // R02
        else $error("frame generator not reset on sync");
    a_pin_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        bit_clock_direction |=> !serial_bit_clock_pin_oe) // R13
        else $error("bit clock pin driven while input");
    a_ext_ignore_div: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (bit_clock_direction && ext_cur_r && !ext_prv_r) |-> tick) // R12
        else $error("external bit clock edge lost");
endmodule // cfs_frame_sync
`default_nettype wire

// >>> testbench/cfs_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_codec_model (
    input  wire logic sys_clk,   // Instruction clock
    input  wire logic run,       // Codec supplies the bit clock
    input  wire logic sck,       // Bit clock wire level
    input  wire logic sync_want, // Frame sync level to present
    output logic      bclk,      // Codec bit clock, low when idle
    output logic      fsync,     // Frame sync pin drive
    output logic      sck_rise   // Pulse after each bit clock rise
);
    logic [1:0] cnt_r;
    logic       prev_r;

    initial begin
        cnt_r = 2'h0;
        prev_r = 1'b0;
        bclk = 1'b0;
        fsync = 1'b0;
        sck_rise = 1'b0;
    end

    // Sync launched on the falling bit clock edge, codec style
    always @(posedge sys_clk) begin
        prev_r   <= sck;
        sck_rise <= sck & ~prev_r;
        if (prev_r & ~sck) begin
            fsync <= sync_want;
        end
        cnt_r <= run ? cnt_r + 2'h1 : 2'h0;
        if (!run) begin
            bclk <= 1'b0;
        end else if (cnt_r == 2'h3) begin
            bclk <= ~bclk;
        end
    end
endmodule // cfs_codec_model
`default_nettype wire

// >>> testbench/cfs_frame_sync_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cfs_frame_sync_tb;
    logic                 sys_clk, rst_n, dir, ext, sync_want, bclk, fsync, sck_rise;
    logic                 pin_o, pin_oe, busy;
    wire logic            sck;
    logic [11:0]          div;
    logic [3:0]           flen, wsz;
    cfs_pkg::cfs_mode_t   mode;
    cfs_pkg::cfs_status_t status;
    int                   errors, n_tests;

    // Wire level from both drivers of the bit clock pin
    assign sck = pin_oe ? pin_o : bclk;

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    cfs_frame_sync dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .mode(mode), .bit_clock_divisor(div),
        .bit_clock_direction(dir), .frame_length_setting(flen), .word_size_setting(wsz),
        .frame_sync_pin(fsync), .serial_bit_clock_pin_i(sck), .serial_bit_clock_pin_o(pin_o),
        .serial_bit_clock_pin_oe(pin_oe), .status(status), .busy(busy)
    );

    cfs_codec_model codec_u (
        .sys_clk(sys_clk), .run(ext), .sck(sck), .sync_want(sync_want),
        .bclk(bclk), .fsync(fsync), .sck_rise(sck_rise)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic stall(input string what);
        check(what, 32'h0, 32'h1);
        complete_run();
    endtask

    // Advance until the generated clock shows level v
    task automatic wait_lvl(input logic v, inout int n);
        int i;
        for (i = 0; i < 40 && pin_o !== v; i++) begin
            @(negedge sys_clk);
            n++;
        end
        if (i == 40) stall("bit clock level");
    endtask

    task automatic t_gen();
        int d, n;
        logic v;
        for (d = 1; d <= 5; d += 2) begin
            div = d[11:0];
            repeat (30) @(negedge sys_clk);
            n = 0;
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            n = 0;
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            check("bit clock period", n, 2 * (d + 1));
            check("pin enable on", pin_oe, 32'h1);
        end
        div = 12'h000;
        repeat (12) @(negedge sys_clk);
        check("pin enable off", pin_oe, 32'h0);
        v = pin_o;
        n = 0;
        repeat (20) begin
            @(negedge sys_clk);
            if (pin_o !== v) n++;
        end
        check("stopped clock toggles", n, 32'h0);
    endtask

    task automatic t_rsvd();
        int n;
        mode = cfs_pkg::CFS_MODE_RSVD;
        sync_want = 1'b1;
        n = 0;
        repeat (60) begin
            @(negedge sys_clk);
            if (status.frame_start !== 1'b0 || busy !== 1'b0) n++;
        end
        check("reserved mode starts", n, 32'h0);
        sync_want = 1'b0;
        repeat (20) @(negedge sys_clk);
    endtask

    // Sync to lvl, extra sync edges inside the frame, count ticks
    task automatic run_frame(input cfs_pkg::cfs_mode_t m, input logic [3:0] fl, input logic [3:0] w,
                             input logic lvl);
        int i, rises, bits, starts, late, slots, bad;
        logic [3:0] b_exp, s_exp;
        mode = m;
        flen = fl;
        wsz = w;
        sync_want = lvl;
        for (i = 0; i < 40 && fsync !== lvl; i++) @(negedge sys_clk);
        if (i == 40) stall("sync level");
        rises = 0;
        bits = 0;
        starts = 0;
        late = 0;
        slots = 0;
        bad = 0;
        b_exp = 4'h0;
        s_exp = 4'h0;
        // Generated pin rises a cycle after the tick, so allow a short tail
        for (i = 0; i < 3000 && status.frame_done !== 1'b1; i++) begin
            @(negedge sys_clk);
            if (starts > 0) late++;
            if (sck_rise === 1'b1 && (starts == 0 || late < 3)) rises++;
            if (status.frame_start === 1'b1) starts++;
            if (status.slot_start === 1'b1) slots++;
            if (status.bit_strobe === 1'b1) begin
                bits++;
                if (status.bit_index !== b_exp || status.slot_index !== s_exp) bad++;
                if (b_exp == w) begin
                    b_exp = 4'h0;
                    s_exp = s_exp + 4'h1;
                end else begin
                    b_exp = b_exp + 4'h1;
                end
                if (bits == 1 || bits == 3 || (bits == 5 && m != cfs_pkg::CFS_MODE_I2S)) sync_want = ~sync_want;
            end
        end
        if (i == 3000) stall("frame end");
        check("start delay in bit clocks", rises, 32'h2);
        check("frame starts", starts, 32'h1);
        check("frame bits", bits, m == cfs_pkg::CFS_MODE_I2S ? w + 1 : (fl + 1) * (w + 1));
        check("slot starts", slots, m == cfs_pkg::CFS_MODE_I2S ? 32'h1 : fl + 1);
        check("index mismatches", bad, 32'h0);
        check("busy after frame", busy, 32'h0);
        check("pin enable", pin_oe, dir ? 32'h0 : 32'h1);
    endtask

    initial begin
        rst_n = 1'b0;
        dir = 1'b0;
        ext = 1'b0;
        sync_want = 1'b0;
        div = 12'h000;
        flen = 4'h0;
        wsz = 4'h0;
        mode = cfs_pkg::CFS_MODE_MULTI;
        errors = 0;
        n_tests = 0;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check("status after reset", status, 32'h0);
        check("busy after reset", busy, 32'h0);
        check("enable after reset", pin_oe, 32'h0);
        t_gen();
        dir = 1'b1;
        div = 12'hABC;
        ext = 1'b1;
        t_rsvd();
        run_frame(cfs_pkg::CFS_MODE_MULTI, 4'h2, 4'h3, 1'b1);
        run_frame(cfs_pkg::CFS_MODE_ACLINK, 4'h1, 4'h7, 1'b1);
        run_frame(cfs_pkg::CFS_MODE_I2S, 4'h0, 4'h7, 1'b1);
        run_frame(cfs_pkg::CFS_MODE_I2S, 4'h0, 4'h7, 1'b0);
        ext = 1'b0;
        dir = 1'b0;
        div = 12'h003;
        repeat (20) @(negedge sys_clk);
        run_frame(cfs_pkg::CFS_MODE_MULTI, 4'h1, 4'h3, 1'b1);
        complete_run();
    end
endmodule // cfs_frame_sync_tb
`default_nettype wire
